// ---- include/term_consts.vh ----
// constants for the line termination select decoder
// Summary of operation
// - five enables come from speed, termination bit, mode field and two pulldown requests.
// - settings govern the resistors only in synchronous mode; otherwise the enables hold.
// - in synchronous mode, mode field 01b clears all five enables whatever else is set.
// - speed 01b, term 0b, mode 00b, both pulldowns set give only both pull-downs.
// - host chirp, high speed and test J/K give both pull-downs and the hs termination.
// - host full speed, low speed, suspend and resume give only the two pull-downs.
// - no pulldowns, term 1b, speed 00b with mode 10b or speed 01b gives only the D+ pull-up.
// - no pulldowns, speed 00b, term 0b, mode 00b or 10b give only the hs termination.
// - no pulldowns, speed 10b, term 1b, mode 00b or 10b give only the D- pull-up.
// - otg peripheral chirp, fs, suspend and resume give D+ pull-up and D- pull-down.
// - otg peripheral high speed and test J/K give hs termination and D- pull-down.
// - connect detect gives only the D- pull-down.
// - any other combination falls back to both pull-downs only.
// - while chip reset is low all five resistor enables stay off.
`ifndef TERM_CONSTS_VH
`define TERM_CONSTS_VH

// register byte offsets
`define ADR_LINE_CTRL    8'h00
`define ADR_TERM_STATUS  8'h04

// control register fields
`define FLD_SPEED_LO     0
`define FLD_SPEED_HI     1
`define FLD_TERM_SEL     2
`define FLD_OP_LO        3
`define FLD_OP_HI        4
`define FLD_DP_PD        5
`define FLD_DM_PD        6
`define FLD_SYNC_MODE    7
`define CTRL_WIDTH       8
// speed 01b, term 0b, mode 00b, both pulldowns, synchronous mode on
`define CTRL_RESET       8'he1

// line mode field values
`define OP_NORMAL        2'h0
`define OP_TRISTATE      2'h1
`define OP_CHIRP         2'h2

// enable vector order {dp pull-up, dm pull-up, dp pull-down, dm pull-down, hs term}
`define EN_WIDTH         5
`define EN_NONE          5'h00
`define EN_HS            5'h01
`define EN_DM_PD         5'h02
`define EN_BOTH_PD       5'h06
`define EN_DM_PU         5'h08
`define EN_DP_PU         5'h10
`define EN_PD_HS         5'h07
`define EN_DP_PU_DM_PD   5'h12
`define EN_HS_DM_PD      5'h03

`endif

// ---- hw/reset_sync.v ----
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ns
module reset_sync (
  // clock and raw reset
  input  wire clk_sys,
  input  wire reset_n,
  // synchronised reset
  output wire rst_sync_n
);
  reg meta_r;
  reg hold_r;

  // assert at once, release after two edges
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      hold_r <= meta_r;
    end
  end

  assign rst_sync_n = hold_r;
endmodule // reset_sync

// ---- hw/term_decode.v ----
// combinational decode of line settings into five resistor enables
`timescale 1ns/1ns
`include "term_consts.vh"
module term_decode (
  // line settings
  input  wire [1:0]             xcvr_speed_sel,
  input  wire                   termination_sel_bit,
  input  wire [1:0]             line_op_field,
  input  wire                   dplus_pd_request,
  input  wire                   dminus_pd_request,
  // decoded enables and table hit
  output reg  [`EN_WIDTH-1:0]   enables,
  output reg                    combo_valid
);
  wire [6:0] key;

  assign key = {xcvr_speed_sel, termination_sel_bit, line_op_field,
                dplus_pd_request, dminus_pd_request};

  // tri-state row wins before any table lookup
  always @* begin
    enables     = `EN_BOTH_PD;
    combo_valid = 1'b1;
    if (line_op_field == `OP_TRISTATE) begin
      enables = `EN_NONE;
    end else begin
      casez (key)
        7'b01_0_00_11: enables = `EN_BOTH_PD;
        7'b00_0_00_11: enables = `EN_PD_HS;
        7'b00_0_10_11: enables = `EN_PD_HS;
        7'b?1_1_00_11: enables = `EN_BOTH_PD;
        7'b01_1_10_11: enables = `EN_BOTH_PD;
        7'b10_1_00_11: enables = `EN_BOTH_PD;
        7'b10_1_10_11: enables = `EN_BOTH_PD;
        7'b00_1_10_00: enables = `EN_DP_PU;
        7'b01_1_00_00: enables = `EN_DP_PU;
        7'b01_1_10_00: enables = `EN_DP_PU;
        7'b00_0_00_00: enables = `EN_HS;
        7'b00_0_10_00: enables = `EN_HS;
        7'b10_1_00_00: enables = `EN_DM_PU;
        7'b10_1_10_00: enables = `EN_DM_PU;
        7'b00_1_10_01: enables = `EN_DP_PU_DM_PD;
        7'b01_1_00_01: enables = `EN_DP_PU_DM_PD;
        7'b01_1_10_01: enables = `EN_DP_PU_DM_PD;
        7'b00_0_00_01: enables = `EN_HS_DM_PD;
        7'b00_0_10_01: enables = `EN_HS_DM_PD;
        7'b01_0_00_01: enables = `EN_DM_PD;
        // unlisted settings: unsupported, both pull-downs only
        default: begin
          enables     = `EN_BOTH_PD;
          combo_valid = 1'b0;
        end
      endcase
    end
  end
endmodule // term_decode

// ---- hw/term_select_top.v ----
// line termination select block with a classic wishbone register slave
`timescale 1ns/1ns
`include "term_consts.vh"
module term_select_top (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // resistor enables
  output reg         dplus_pullup_on,
  output reg         dminus_pullup_on,
  output reg         dplus_pulldown_on,
  output reg         dminus_pulldown_on,
  output reg         hs_termination_on
);
  wire                  rst_n;
  wire [`EN_WIDTH-1:0]  dec_en;
  wire                  dec_valid;
  wire                  req;
  wire [`EN_WIDTH-1:0]  en_now;
  reg  [`CTRL_WIDTH-1:0] ctrl_r;
  reg                   valid_r;
  reg  [31:0]           rdata_nxt;

  // release of the async reset is synchronised so all flops leave reset together
  reset_sync u_reset_sync (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .rst_sync_n (rst_n)
  );

  // decode works straight from the stored control bits
  term_decode u_term_decode (
    .xcvr_speed_sel      (ctrl_r[`FLD_SPEED_HI:`FLD_SPEED_LO]),
    .termination_sel_bit (ctrl_r[`FLD_TERM_SEL]),
    .line_op_field       (ctrl_r[`FLD_OP_HI:`FLD_OP_LO]),
    .dplus_pd_request    (ctrl_r[`FLD_DP_PD]),
    .dminus_pd_request   (ctrl_r[`FLD_DM_PD]),
    .enables             (dec_en),
    .combo_valid         (dec_valid)
  );

  // new request: one ack per strobe, none in the cycle after an ack
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  assign en_now = {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
                   dminus_pulldown_on, hs_termination_on};

  // read mux; unmapped offsets read as zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `ADR_LINE_CTRL:   rdata_nxt = {24'h00_0000, ctrl_r};
      `ADR_TERM_STATUS: rdata_nxt = {26'h000_0000, valid_r, en_now};
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // bus answer one cycle after the request, dropped the next cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= rdata_nxt;
    end
  end

  // control register, byte lane 0 only; writes to other offsets are dropped
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADR_LINE_CTRL) begin
      ctrl_r <= wb_dat_i[`CTRL_WIDTH-1:0];
    end
  end

  // enables registered one edge after the control bits settle, so a write
  // never shows a partial decode; outside synchronous mode they hold
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dplus_pullup_on    <= 1'b0;
      dminus_pullup_on   <= 1'b0;
      dplus_pulldown_on  <= 1'b0;
      dminus_pulldown_on <= 1'b0;
      hs_termination_on  <= 1'b0;
      valid_r            <= 1'b0;
    end else if (ctrl_r[`FLD_SYNC_MODE]) begin
      {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
       dminus_pulldown_on, hs_termination_on} <= dec_en;
      valid_r <= dec_valid;
    end
  end
endmodule // term_select_top

// ---- tb/term_select_assertions.sv ----
// port checks for the termination select block
`timescale 1ns/1ns
module term_select_assertions (
  // clock, reset and bus handshake
  input wire        clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i, wb_dat_o,
  // resistor enables
  input wire        dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
  input wire        dminus_pulldown_on, hs_termination_on
);
  wire [4:0] en = {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on,
                   dminus_pulldown_on, hs_termination_on};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a ctrl write taken at this edge; enables follow two edges on
  sequence s_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0];
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too wide");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_tristate_clear: assert property (
    s_wr ##0 (wb_dat_i[7] && wb_dat_i[4:3] == 2'b01) |-> ##2 en == 5'h00)
    else $error("tri-state mode left an enable on");
  a_mode_fallback: assert property (
    s_wr ##0 (wb_dat_i[7] && wb_dat_i[4:3] == 2'b11) |-> ##2 en == 5'h06)
    else $error("mode 11 did not fall back");
  a_async_hold: assert property (s_wr ##0 !wb_dat_i[7] |-> ##2 $stable(en))
    else $error("enables moved outside synchronous mode");
  a_reset_off: assert property (disable iff (1'b0) !reset_n |-> en == 5'h00 && !wb_ack_o)
    else $error("enable on during reset");
  a_change_cause: assert property (
    $changed(en) && $past(en) != 5'h00 |-> $past(wb_ack_o))
    else $error("enables changed without a write");
endmodule // term_select_assertions
bind term_select_top term_select_assertions chk_u (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .dplus_pullup_on,
  .dminus_pullup_on, .dplus_pulldown_on, .dminus_pulldown_on, .hs_termination_on);

// ---- tb/link_wb_master.sv ----
// wishbone master standing in for the link controller
`timescale 1ns/1ns
module link_wb_master (
  // clock
  input  wire        clk_sys,
  // bus
  output reg         wb_cyc_o, wb_stb_o, wb_we_o,
  output reg  [7:0]  wb_adr_o,
  output reg  [3:0]  wb_sel_o,
  output reg  [31:0] wb_dat_o,
  input  wire [31:0] wb_dat_i,
  input  wire        wb_ack_i
);
  initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = 47'h0;
  // one classic cycle; released lines flip so stale values never look valid
  task xfer(input w, input [7:0] a, input [3:0] s, input [31:0] d,
            output [31:0] q, output ok);
    integer n;
    begin
      ok = 1'b0;
      q = 32'h0;
      @(posedge clk_sys);
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'b11, w, a, s, d};
      for (n = 0; n < 16 && !ok; n = n + 1) begin
        @(posedge clk_sys);
        if (wb_ack_i === 1'b1) begin
          q = wb_dat_i;
          ok = 1'b1;
        end
      end
      {wb_cyc_o, wb_stb_o, wb_adr_o, wb_dat_o} <= {2'b00, ~a, ~d};
      @(posedge clk_sys);
    end
  endtask
endmodule // link_wb_master

// ---- tb/usb_termination_select_decoder_tb_top.sv ----
// self-checking bench for the termination select block
`timescale 1ns/1ns
module usb_termination_select_decoder_tb_top;
  reg          clk_sys = 1'b0;
  reg          reset_n = 1'b1;
  wire         cyc, stb, we, ack;
  wire [7:0]   adr;
  wire [3:0]   sel;
  wire [31:0]  wd, rdat;
  wire [4:0]   en;
  reg  [31:0]  q;
  reg          ok;
  reg  [7:0]   ctl_m = 8'he1;
  reg  [5:0]   en_m = 6'h26;
  integer      error_cnt = 0, checks = 0, seed = 86625, i;
  // listed settings, then tri-state, mode 11 and a lone D+ request
  reg  [191:0] tbl = {96'he1e0f0e5e7f5e6f694809085, 96'h958696d4c0c5d5d0c18b98a1};
  always #2 clk_sys = ~clk_sys;
  link_wb_master lm_u (.clk_sys, .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wd), .wb_dat_i(rdat), .wb_ack_i(ack));
  term_select_top dut_u (.clk_sys, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dplus_pullup_on(en[4]), .dminus_pullup_on(en[3]), .dplus_pulldown_on(en[2]),
    .dminus_pulldown_on(en[1]), .hs_termination_on(en[0]));
  // decode model {table hit, enables}; anything unmatched keeps both pull-downs, hit low
  function [5:0] model(input [7:0] c);
    reg [1:0] s, o, p;
    reg       t;
    begin
      {p, o, t, s} = c[6:0];
      model = 6'h06;
      if (o == 2'b01) model = 6'h20;
      else if (!o[0]) begin
        if (p == 3 && !t && s == 1 && o == 0) model = 6'h26;
        if (p == 3 && t && s != 0 && !(o == 2 && s == 3)) model = 6'h26;
        if (p == 3 && s == 0 && !t) model = 6'h27;
        if (p == 0 && s == 0 && !t) model = 6'h21;
        if (p == 2 && s == 0 && !t) model = 6'h23;
        if (!p[0] && t && (s == 1 || s == 0 && o == 2))
          model = p[1] ? 6'h32 : 6'h30;
        if (p == 0 && t && s == 2) model = 6'h28;
        if (p == 2 && !t && s == 1 && o == 0) model = 6'h22;
      end
    end
  endfunction
  task end_sim;
    begin
      $display("errors=%0d checks=%0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task cmp_rd(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_en(input [4:0] exp);
    cmp_rd({27'h0, en}, {27'h0, exp});
  endtask
  // a lost answer ends the run at once
  task go(input w, input [7:0] a, input [3:0] s, input [31:0] d);
    begin
      lm_u.xfer(w, a, s, d, q, ok);
      if (!ok) begin
        error_cnt = error_cnt + 1;
        end_sim;
      end
    end
  endtask
  task wr(input [7:0] a, input [3:0] s, input [31:0] d);
    begin
      go(1'b1, a, s, d);
      if (a == 8'h00 && s[0]) ctl_m = d[7:0];
      if (ctl_m[7]) en_m = model(ctl_m);
      cmp_en(en_m[4:0]);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] m);
    begin
      go(1'b0, a, 4'hf, 32'h0);
      cmp_rd(q & m, e);
    end
  endtask
  initial begin
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp_en(5'h06);
    rd(8'h00, 32'he1, 32'hffffffff);
    rd(8'h04, 32'h26, 32'h3f);
    for (i = 0; i < 24; i = i + 1) wr(8'h00, 4'h1, tbl[191 - 8 * i -: 8]);
    wr(8'h00, 4'hf, 32'h05);
    wr(8'h00, 4'hf, 32'h0b);
    rd(8'h04, {26'h0, en_m}, 32'h3f);
    wr(8'h00, 4'he, 32'h8b);
    wr(8'h04, 4'hf, 32'h8b);
    wr(8'h10, 4'hf, 32'h8b);
    rd(8'h10, 32'h0, 32'hffffffff);
    rd(8'h00, 32'h0b, 32'hffffffff);
    for (i = 0; i < 40; i = i + 1) begin
      wr(8'h00, 4'hf, $random(seed));
      rd(8'h04, {26'h0, en_m}, 32'h3f);
    end
    reset_n <= 1'b0;
    @(posedge clk_sys);
    cmp_en(5'h00);
    reset_n <= 1'b1;
    ctl_m = 8'he1;
    en_m = 6'h26;
    repeat (4) @(posedge clk_sys);
    cmp_en(en_m[4:0]);
    rd(8'h00, 32'he1, 32'hffffffff);
    rd(8'h04, {26'h0, en_m}, 32'h3f);
    end_sim;
  end
endmodule // usb_termination_select_decoder_tb_top
